// [mfos_serializer.v]
// MAC frame octet serializer toward the physical layer transmit port
// Operation
// RULE1 - Subtype sits in frame control bits 12..9
// RULE2 - Plain frame: header, payload, checksum
// RULE3 - Secure: header, security header, payload, integrity, checksum
// RULE4 - Key handshake payload fields in fixed order
// RULE5 - Multi-octet header fields go out LSB first
`timescale 1ns/1ps
`default_nettype none
`include "mfos_defs.vh"
module mfos_serializer (
  input wire core_clk,
  input wire rst,
  // Frame request, sampled on start
  input wire start,
  input wire [1:0] kind,
  input wire [15:0] frame_control,
  input wire [3:0] subtype,
  input wire [15:0] dest_addr,
  input wire [15:0] src_addr,
  input wire [15:0] seq_control,
  input wire [15:0] access_info,
  input wire [23:0] temporal_key_id,
  input wire [15:0] cipher_start_offset,
  input wire [47:0] secure_frame_number,
  input wire [7:0] message_number,
  input wire [7:0] status_code,
  input wire [23:0] pairwise_key_identifier,
  input wire [127:0] master_key_identifier,
  input wire [127:0] responder_nonce,
  input wire [63:0] integrity_code,
  input wire [31:0] check_sequence,
  // Payload stream from MAC logic
  input wire pay_valid,
  input wire [7:0] pay_data,
  input wire pay_last,
  output wire pay_ready,
  // Octet stream to the physical layer
  output reg tx_valid,
  output reg [7:0] tx_data,
  output reg tx_last,
  input wire tx_ready,
  output wire busy
);
  // One-hot phases
  localparam S_IDLE = 9'h001;
  localparam S_MHDR = 9'h002;
  localparam S_SHDR = 9'h004;
  localparam S_PAY = 9'h008;
  localparam S_KMSG = 9'h010;
  localparam S_KRSV = 9'h020;
  localparam S_KKEY = 9'h040;
  localparam S_MIC = 9'h080;
  localparam S_FCS = 9'h100;
  reg [8:0] state; // Current phase
  reg [8:0] next_state;
  reg [4:0] idx; // Octet index within phase
  reg [1:0] kind_q; // Latched frame kind
  reg [79:0] mhdr; // Latched MAC header
  reg [95:0] shdr; // Latched security header
  reg [63:0] mic; // Latched integrity code
  reg [31:0] fcs; // Latched checksum
  reg [39:0] kmsg; // Message, status, key id
  reg [255:0] kkey; // Master key id then nonce
  wire [7:0] mhdr_oct;
  wire [7:0] shdr_oct;
  wire [7:0] mic_oct;
  wire [7:0] fcs_oct;
  wire [7:0] kmsg_oct;
  wire [7:0] kkey_oct;
  reg [7:0] cur_oct; // Octet for this phase
  reg [4:0] last_idx; // Final index in phase
  wire out_free; // Output register can take an octet
  wire advance; // One octet moves this cycle
  wire pay_take;
  assign out_free = !tx_valid || tx_ready;
  assign busy = (state != S_IDLE);
  assign pay_take = (state == S_PAY) && out_free;
  // Payload only flows when the output register has room
  assign pay_ready = pay_take;
  assign advance = out_free && (state != S_IDLE) && ((state != S_PAY) || pay_valid);
  // Byte pickers, field order fixed by concatenation
  mfos_le_field #(.OCTETS(10)) u_mhdr (.field(mhdr), .index(idx[3:0]), .octet(mhdr_oct));
  mfos_le_field #(.OCTETS(12)) u_shdr (.field(shdr), .index(idx[3:0]), .octet(shdr_oct));
  mfos_le_field #(.OCTETS(8)) u_mic (.field(mic), .index(idx[3:0]), .octet(mic_oct));
  mfos_le_field #(.OCTETS(4)) u_fcs (.field(fcs), .index(idx[3:0]), .octet(fcs_oct));
  mfos_le_field #(.OCTETS(5)) u_kmsg (.field(kmsg), .index(idx[3:0]), .octet(kmsg_oct));
  // Key and nonce are given already in transmit order, first octet in low bits
  assign kkey_oct = kkey[8*idx +: 8]; // RULE4
  // Octet select and phase length
  always @* begin
    cur_oct = 8'h00;
    last_idx = 5'h00;
    case (state)
      S_MHDR: begin
        cur_oct = mhdr_oct;
        last_idx = {1'b0, `MFOS_MAC_HDR_LEN} - 5'h01;
      end
      S_SHDR: begin
        cur_oct = shdr_oct;
        last_idx = {1'b0, `MFOS_SEC_HDR_LEN} - 5'h01;
      end
      S_PAY: begin
        cur_oct = pay_data;
      end
      S_KMSG: begin
        cur_oct = kmsg_oct;
        last_idx = 5'h04;
      end
      S_KRSV: begin
        // Reserved octets are zero
        last_idx = {1'b0, `MFOS_KH_RSVD_LEN} - 5'h01; // RULE4
      end
      S_KKEY: begin
        cur_oct = kkey_oct;
        last_idx = 5'h1F;
      end
      S_MIC: begin
        cur_oct = mic_oct;
        last_idx = {1'b0, `MFOS_MIC_LEN} - 5'h01;
      end
      S_FCS: begin
        cur_oct = fcs_oct;
        last_idx = {1'b0, `MFOS_FCS_LEN} - 5'h01;
      end
      default: begin
        cur_oct = 8'h00;
      end
    endcase
  end
  // Phase sequencing per frame kind
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_MHDR;
        end
      end
      S_MHDR: begin
        if (advance && idx == last_idx) begin
          if (kind_q == `MFOS_KIND_SECURE) begin
            next_state = S_SHDR; // RULE3
          end else if (kind_q == `MFOS_KIND_KEYHS) begin
            next_state = S_KMSG; // RULE4
          end else begin
            next_state = S_PAY; // RULE2
          end
        end
      end
      S_SHDR: begin
        if (advance && idx == last_idx) begin
          next_state = S_PAY; // RULE3
        end
      end
      S_PAY: begin
        if (advance && pay_last) begin
          // Secure frames carry the integrity code before the checksum
          next_state = (kind_q == `MFOS_KIND_SECURE) ? S_MIC : S_FCS; // RULE2 RULE3
        end
      end
      S_KMSG: begin
        if (advance && idx == last_idx) begin
          next_state = S_KRSV; // RULE4
        end
      end
      S_KRSV: begin
        if (advance && idx == last_idx) begin
          next_state = S_KKEY; // RULE4
        end
      end
      S_KKEY: begin
        if (advance && idx == last_idx) begin
          next_state = S_MIC; // RULE4
        end
      end
      S_MIC: begin
        if (advance && idx == last_idx) begin
          next_state = S_FCS;
        end
      end
      S_FCS: begin
        if (advance && idx == last_idx) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end
  // State, index and field capture
  always @(posedge core_clk) begin
    if (rst) begin
      state <= S_IDLE;
      idx <= 5'h00;
      kind_q <= `MFOS_KIND_PLAIN;
      mhdr <= 80'h0;
      shdr <= 96'h0;
      mic <= 64'h0;
      fcs <= 32'h0;
      kmsg <= 40'h0;
      kkey <= 256'h0;
    end else begin
      state <= next_state;
      if (state == S_IDLE && start) begin
        // Latch everything so inputs may change mid-frame
        kind_q <= kind;
        mhdr <= {access_info, seq_control, src_addr, dest_addr,
          frame_control[15:`MFOS_FC_SUBTYPE_HI+1], subtype,
          frame_control[`MFOS_FC_SUBTYPE_LO-1:0]}; // RULE1 RULE5
        // Key id low octet leads, then the reserved zero octet, offset, frame number
        shdr <= {secure_frame_number, cipher_start_offset, 8'h00, temporal_key_id}; // RULE3
        mic <= integrity_code;
        fcs <= check_sequence;
        // Key id above status above message number, low first
        kmsg <= {pairwise_key_identifier, status_code, message_number}; // RULE4
        kkey <= {responder_nonce, master_key_identifier}; // RULE4
        idx <= 5'h00;
      end else if (advance) begin
        // Index resets at each phase change
        idx <= (next_state != state) ? 5'h00 : idx + 5'h01;
      end
    end
  end
  // Output register with back-pressure
  always @(posedge core_clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else if (advance) begin
      tx_valid <= 1'b1;
      tx_data <= cur_oct;
      tx_last <= (state == S_FCS) && (idx == last_idx);
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [mfos_defs.vh]
// Constants for the MAC frame octet serializer
`ifndef MFOS_DEFS_VH
`define MFOS_DEFS_VH
// Header, integrity and checksum section lengths in octets
`define MFOS_MAC_HDR_LEN 4'hA
`define MFOS_SEC_HDR_LEN 4'hC
`define MFOS_MIC_LEN 4'h8
`define MFOS_FCS_LEN 4'h4
// Key handshake payload field lengths in octets
`define MFOS_KH_RSVD_LEN 4'hB
`define MFOS_KH_KEY_LEN 5'h10
// Frame control subtype field position
`define MFOS_FC_SUBTYPE_HI 12
`define MFOS_FC_SUBTYPE_LO 9
// Frame kinds selected at start
`define MFOS_KIND_PLAIN 2'h0
`define MFOS_KIND_SECURE 2'h1
`define MFOS_KIND_KEYHS 2'h2
`endif

// [mfos_le_field.v]
// Little-endian octet picker for one multi-octet field
`timescale 1ns/1ps
`default_nettype none
module mfos_le_field #(
  parameter OCTETS = 6
) (
  input wire [8*OCTETS-1:0] field,
  input wire [3:0] index,
  output reg [7:0] octet
);
  // Least significant octet goes out first
  always @* begin
    octet = field[8*index +: 8]; // RULE5
  end
endmodule
`default_nettype wire

// [mfos_properties.sv]
// Port checks for the octet serializer
`timescale 1ns/1ps
`default_nettype none
module mfos_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] frame_control,
  input wire logic busy,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic pay_valid,
  input wire logic pay_last,
  input wire logic pay_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  hold_octet_a: assert property (tx_valid && !tx_ready |=> $stable({tx_valid, tx_data, tx_last}))
    else $error("octet moved while stalled");
  first_octet_a: assert property (start && !busy |-> ##2 tx_valid && tx_data == $past(frame_control[7:0], 2))
    else $error("first octet not control low");
  take_start_a: assert property (start && !busy |=> busy)
    else $error("start not taken");
  pay_gate_a: assert property (pay_ready |-> busy)
    else $error("payload taken while idle");
  pay_end_a: assert property (pay_valid && pay_ready && pay_last |=> !pay_ready)
    else $error("payload kept after last");
  frame_end_a: assert property ($fell(busy) && !$past(rst) |-> tx_valid && tx_last)
    else $error("frame ended without last octet");
  idle_quiet_a: assert property (!busy && !start && !tx_valid |=> !tx_valid)
    else $error("octet offered while idle");
  // Main scenarios: stall, payload end, frame end
  cover property (tx_valid && !tx_ready);
  cover property (pay_valid && pay_ready && pay_last);
  cover property ($fell(busy));
endmodule
`default_nettype wire

// [mfos_phy_sink.sv]
// Physical layer transmit sink that stalls at random
`timescale 1ns/1ps
`default_nettype none
module mfos_phy_sink (
  input wire logic core_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] got [$]; // Octets taken, oldest first
  int frames = 0; // Frames closed by a last octet
  int seed = 32'h5A5A; // Own stream, keeps bench draws apart
  // Random ready mixes prompt and slow answers; single driver, settles during reset
  always @(negedge core_clk) tx_ready <= ($random(seed) & 3) != 0;
  // One octet per handshake, in offered order
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      frames <= frames + tx_last;
    end
  end
endmodule
`default_nettype wire

// [mfos_serializer_tb.sv]
// Self-checking bench for the octet serializer
`timescale 1ns/1ps
`default_nettype none
`include "mfos_defs.vh"
module mfos_serializer_tb;
  logic core_clk = 0, rst = 1, start = 0, pay_valid = 0, pay_last = 0, took;
  logic [1:0] kind = 0;
  logic [7:0] pay_data = 0, message_number, status_code, tx_data;
  logic [15:0] frame_control, dest_addr, src_addr, seq_control, access_info, cipher_start_offset;
  logic [3:0] subtype;
  logic [23:0] temporal_key_id, pairwise_key_identifier;
  logic [47:0] secure_frame_number;
  logic [127:0] master_key_identifier, responder_nonce;
  logic [63:0] integrity_code;
  logic [31:0] check_sequence;
  logic pay_ready, tx_valid, tx_last, tx_ready, busy;
  logic [563:0] r = 0; // All frame fields, redrawn per frame
  logic [7:0] exp [$], pay [$];
  int seed = 32'h3607, err_count = 0, n_compared = 0, nf = 0;
  assign {frame_control, subtype, dest_addr, src_addr, seq_control, access_info,
    temporal_key_id, cipher_start_offset, secure_frame_number, message_number, status_code,
    pairwise_key_identifier, master_key_identifier, responder_nonce, integrity_code,
    check_sequence} = r;
  always #12.5 core_clk = ~core_clk;
  // Flop the payload handshake so the driver never races it
  always @(posedge core_clk) took <= pay_valid && pay_ready;
  mfos_serializer u_mfos_serializer (
    .core_clk(core_clk), .rst(rst), .start(start), .kind(kind),
    .frame_control(frame_control), .subtype(subtype), .dest_addr(dest_addr),
    .src_addr(src_addr), .seq_control(seq_control), .access_info(access_info),
    .temporal_key_id(temporal_key_id), .cipher_start_offset(cipher_start_offset),
    .secure_frame_number(secure_frame_number), .message_number(message_number),
    .status_code(status_code), .pairwise_key_identifier(pairwise_key_identifier),
    .master_key_identifier(master_key_identifier), .responder_nonce(responder_nonce),
    .integrity_code(integrity_code), .check_sequence(check_sequence),
    .pay_valid(pay_valid), .pay_data(pay_data), .pay_last(pay_last), .pay_ready(pay_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .busy(busy)
  );
  mfos_phy_sink u_mfos_phy_sink (
    .core_clk(core_clk), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready)
  );
  function automatic void put(input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) exp.push_back(v[8*i +: 8]);
  endfunction
  // Expected octet stream, low octet of each field first
  function automatic void predict();
    exp.delete();
    put({access_info, seq_control, src_addr, dest_addr, frame_control[15:13], subtype,
      frame_control[8:0]}, 10);
    if (kind == `MFOS_KIND_SECURE)
      put({secure_frame_number, cipher_start_offset, 8'h00, temporal_key_id}, 12);
    if (kind == `MFOS_KIND_KEYHS) begin
      put({pairwise_key_identifier, status_code, message_number}, 5);
      put(0, 11);
      put(master_key_identifier, 16);
      put(responder_nonce, 16);
    end else foreach (pay[i]) exp.push_back(pay[i]);
    if (kind inside {`MFOS_KIND_SECURE, `MFOS_KIND_KEYHS}) put(integrity_code, 8);
    put(check_sequence, 4);
  endfunction
  task automatic err(input string m);
    err_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic print_verdict();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One frame, with a stray start while busy that must be ignored
  task automatic frame(input logic [1:0] k, input int len);
    int w;
    pay.delete();
    repeat (len) pay.push_back(8'($random(seed)));
    for (int i = 0; i < 18; i++) r = {r[531:0], $random(seed)};
    kind = k;
    u_mfos_phy_sink.got.delete();
    start = 1;
    @(negedge core_clk) start = 0;
    predict();
    @(negedge core_clk) start = 1;
    n_compared++;
    if (busy !== 1'b1) err("busy low after start");
    @(negedge core_clk) start = 0;
    if (k != `MFOS_KIND_KEYHS) foreach (pay[i]) begin
      pay_data = pay[i];
      pay_last = i == len - 1;
      pay_valid = 1;
      do @(negedge core_clk); while (!took);
    end
    pay_valid = 0;
    pay_last = 0;
    nf++;
    w = 0;
    while (u_mfos_phy_sink.frames != nf && w++ < 500) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    n_compared++;
    if (u_mfos_phy_sink.got.size() != exp.size() || u_mfos_phy_sink.frames != nf) err("length");
    else foreach (exp[i]) if (u_mfos_phy_sink.got[i] !== exp[i]) err("octet");
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    frame(`MFOS_KIND_PLAIN, 1);
    frame(2'h3, 1);
    frame(`MFOS_KIND_SECURE, 1);
    frame(`MFOS_KIND_KEYHS, 0);
    repeat (40) frame(2'($random(seed)), 1 + ($random(seed) & 15));
    print_verdict();
  end
  // Hang guard well past the longest expected run
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
endmodule
bind mfos_serializer mfos_props u_mfos_props (
  .core_clk(core_clk), .rst(rst), .start(start), .frame_control(frame_control),
  .busy(busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .tx_ready(tx_ready), .pay_valid(pay_valid), .pay_last(pay_last), .pay_ready(pay_ready)
);
`default_nettype wire
